// ===== conv_mode_pkg.sv
// constants shared by the converter control-mode select logic
package conv_mode_pkg;

  // ----------------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 16;
  localparam int FRAME_BITS = ADDR_W + DATA_W;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------------
  // synchronised pin vector positions
  // ----------------------------------------------------------------------
  localparam int PIN_COUNT      = 8;
  localparam int PIN_MODE_LVL   = 0;
  localparam int PIN_MODE_FLT   = 1;
  localparam int PIN_SWING_LVL  = 2;
  localparam int PIN_SWING_FLT  = 3;
  localparam int PIN_EDGE_LVL   = 4;
  localparam int PIN_EDGE_FLT   = 5;
  localparam int PIN_CAL_LVL    = 6;
  localparam int PIN_CAL_FLT    = 7;

  // ----------------------------------------------------------------------
  // user register map
  // ----------------------------------------------------------------------
  localparam int NUM_REGS = 8;
  localparam int CFG_IDX  = 0;
  localparam int DES_IDX  = 6;
  localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFS = {
    4'he, 4'hd, 4'hb, 4'ha, 4'h9, 4'h3, 4'h2, 4'h1};
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0011;
  localparam logic [DATA_W-1:0] DES_RESET = 16'h3fff;
  localparam logic [DATA_W-1:0] GEN_RESET = 16'h0000;
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
    GEN_RESET, DES_RESET, GEN_RESET, GEN_RESET,
    GEN_RESET, GEN_RESET, GEN_RESET, CFG_RESET};

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CFG_SWING_BIT = 0;
  localparam int CFG_EDGE_BIT  = 1;
  localparam int CFG_DDR_BIT   = 2;
  localparam int CFG_CAL_BIT   = 3;
  localparam int CFG_FS_BIT    = 4;
  localparam int DES_EN_BIT    = 15;

endpackage : conv_mode_pkg

// ===== serial_cfg_rx.sv
// serial configuration frame receiver, driven by synchronised pin levels
module serial_cfg_rx
  import conv_mode_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          enable,
  input  wire logic          serial_clk,
  input  wire logic          serial_cfg_data,
  input  wire logic          serial_cfg_select_n,
  output logic               wr_stb,
  output logic [AW-1:0]      wr_addr,
  output logic [DW-1:0]      wr_data
);

  if (AW + DW != FRAME_BITS) begin : g_chk
    $error("serial_cfg_rx: frame width mismatch");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              sclk_q;
    logic [4:0]        cnt;
    logic [AW+DW-1:0]  shreg;
    logic              stb;
    logic [AW-1:0]     addr;
    logic [DW-1:0]     data;
  } rx_state_t;

  rx_state_t st_ff;
  rx_state_t nxt_st;
  logic [AW+DW-1:0] shifted;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stb = 1'b0;
    nxt_st.sclk_q = serial_clk;
    shifted = {st_ff.shreg[AW+DW-2:0], serial_cfg_data};
    // select high or strap mode aborts any partial frame
    if (!enable || serial_cfg_select_n) begin
      nxt_st.cnt = 5'h00;
    end else if (serial_clk && !st_ff.sclk_q) begin
      nxt_st.shreg = shifted;
      if (st_ff.cnt == 5'(AW + DW - 1)) begin
        nxt_st.stb = 1'b1;
        nxt_st.addr = shifted[AW+DW-1:DW];
        nxt_st.data = shifted[DW-1:0];
        nxt_st.cnt = 5'h00;
      end else begin
        nxt_st.cnt = st_ff.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wr_stb  = st_ff.stb;
  assign wr_addr = st_ff.addr;
  assign wr_data = st_ff.data;

endmodule : serial_cfg_rx

// ===== conv_mode_select.sv
// control-mode selection: pin-strap decode and serial register file
//
// Contract
// - mode pin driven high or low selects pin-strap mode; host must drive it.
// - mode pin floating selects extended mode with serial interface active.
// - extended mode turns swing, edge, delay pins into serial clock, data, select.
// - strap mode ignores serial writes; settings come only from dedicated pins.
// - strap mode: edge pin high or low picks rising or falling data edge.
// - strap mode: edge pin floating selects double-data-rate output clocking.
// - strap mode: delay pin low short, high long; host must not float it.
// - strap mode: swing pin low reduced swing, high normal swing; must be driven.
module conv_mode_select
  import conv_mode_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 mode_select_level,
  input  wire logic                 mode_select_float,
  input  wire logic                 output_swing_level,
  input  wire logic                 output_swing_float,
  input  wire logic                 output_edge_select_level,
  input  wire logic                 output_edge_select_float,
  input  wire logic                 calibration_delay_select_level,
  input  wire logic                 calibration_delay_select_float,
  output logic                      extended_mode,
  output logic                      output_swing_normal,
  output logic                      data_on_rising_edge,
  output logic                      ddr_clocking,
  output logic                      cal_delay_long,
  output logic                      full_scale_normal,
  output logic                      cal_permit,
  output logic                      dual_edge_active,
  output logic                      first_write_error,
  output logic [NUM_REGS-1:0]       regs_written,
  output logic [DATA_W-1:0]         dual_edge_value
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [PIN_COUNT-1:0]             s1;
    logic [PIN_COUNT-1:0]             s2;
    logic [PIN_COUNT-1:0]             s3;
    logic [PIN_COUNT-1:0]             stb;
    logic                             ext;
    logic                             swing;
    logic                             edge_r;
    logic                             ddr;
    logic                             cal_long;
    logic                             fs_normal;
    logic                             cal_ok;
    logic                             dual_en;
    logic                             proto_err;
    logic [NUM_REGS-1:0]              written;
    logic [NUM_REGS-1:0][DATA_W-1:0]  regs;
  } ctl_state_t;

  ctl_state_t           st_ff;
  ctl_state_t           nxt_st;
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] differ;
  logic                 wr_stb;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic                 ext_now;

  assign pins = {calibration_delay_select_float, calibration_delay_select_level,
                 output_edge_select_float, output_edge_select_level,
                 output_swing_float, output_swing_level,
                 mode_select_float, mode_select_level};
  assign differ  = st_ff.s2 ^ st_ff.s3;
  assign ext_now = st_ff.stb[PIN_MODE_FLT];

  // ----------------------------------------------------------------------
  // serial receiver on the repurposed pins
  // ----------------------------------------------------------------------
  serial_cfg_rx #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_rx (
    .core_clk            (core_clk),
    .sys_rst             (sys_rst),
    .enable              (ext_now),
    .serial_clk          (st_ff.stb[PIN_SWING_LVL]),
    .serial_cfg_data     (st_ff.stb[PIN_EDGE_LVL]),
    .serial_cfg_select_n (st_ff.stb[PIN_CAL_LVL]),
    .wr_stb              (wr_stb),
    .wr_addr             (wr_addr),
    .wr_data             (wr_data)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // s1 feeds s2 only; a level counts once s2 and s3 agree
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.stb = (~differ & st_ff.s3) | (differ & st_ff.stb);
    nxt_st.ext = ext_now;
    // register writes only land in extended mode
    if (ext_now && wr_stb) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_addr == REG_OFS[i]) begin
          if (i == DES_IDX && !st_ff.written[i] && wr_data != DES_RESET) begin
            // refuse the value so the converter never sees it
            nxt_st.proto_err = 1'b1;
          end else begin
            nxt_st.regs[i] = wr_data;
            nxt_st.written[i] = 1'b1;
          end
        end
      end
    end
    if (!ext_now) begin
      nxt_st.swing = st_ff.stb[PIN_SWING_LVL];
      nxt_st.edge_r = st_ff.stb[PIN_EDGE_LVL];
      nxt_st.ddr = st_ff.stb[PIN_EDGE_FLT];
      nxt_st.cal_long = st_ff.stb[PIN_CAL_LVL];
      nxt_st.fs_normal = st_ff.stb[PIN_MODE_LVL];
      nxt_st.cal_ok = 1'b1;
      nxt_st.dual_en = 1'b0;
    end else begin
      nxt_st.swing = st_ff.regs[CFG_IDX][CFG_SWING_BIT];
      nxt_st.edge_r = st_ff.regs[CFG_IDX][CFG_EDGE_BIT];
      nxt_st.ddr = st_ff.regs[CFG_IDX][CFG_DDR_BIT];
      nxt_st.cal_long = st_ff.regs[CFG_IDX][CFG_CAL_BIT];
      nxt_st.fs_normal = st_ff.regs[CFG_IDX][CFG_FS_BIT];
      nxt_st.cal_ok = &nxt_st.written;
      nxt_st.dual_en = (&nxt_st.written) & nxt_st.regs[DES_IDX][DES_EN_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.regs <= REG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign extended_mode       = st_ff.ext;
  assign output_swing_normal = st_ff.swing;
  assign data_on_rising_edge = st_ff.edge_r;
  assign ddr_clocking        = st_ff.ddr;
  assign cal_delay_long      = st_ff.cal_long;
  assign full_scale_normal   = st_ff.fs_normal;
  assign cal_permit          = st_ff.cal_ok;
  assign dual_edge_active    = st_ff.dual_en;
  assign first_write_error   = st_ff.proto_err;
  assign regs_written        = st_ff.written;
  assign dual_edge_value     = st_ff.regs[DES_IDX];

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_strap_mode;
    !st_ff.stb[PIN_MODE_FLT] |=> !extended_mode;
  endproperty
  a_strap_mode: assert property (p_strap_mode) else $error("strap mode not taken");

  property p_ext_mode;
    st_ff.stb[PIN_MODE_FLT] |=> extended_mode;
  endproperty
  a_ext_mode: assert property (p_ext_mode) else $error("extended mode not taken");

  property p_serial_cfg_write;
    ext_now && wr_stb && wr_addr == REG_OFS[CFG_IDX]
      |=> regs_written[CFG_IDX] && st_ff.regs[CFG_IDX] == $past(wr_data);
  endproperty
  a_serial_cfg_write: assert property (p_serial_cfg_write) else $error("serial write lost");

  property p_strap_ignores_serial;
    !ext_now |=> $stable(regs_written) && $stable(dual_edge_value);
  endproperty
  a_strap_ignores_serial: assert property (p_strap_ignores_serial)
    else $error("register changed in strap mode");

  property p_edge_select;
    !ext_now |=> data_on_rising_edge == $past(st_ff.stb[PIN_EDGE_LVL]);
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("edge select wrong");

  property p_ddr_float;
    !ext_now |=> ddr_clocking == $past(st_ff.stb[PIN_EDGE_FLT]);
  endproperty
  a_ddr_float: assert property (p_ddr_float) else $error("ddr select wrong");

  property p_cal_delay;
    !ext_now ##1 !ext_now |-> cal_delay_long == $past(st_ff.stb[PIN_CAL_LVL]);
  endproperty
  a_cal_delay: assert property (p_cal_delay) else $error("cal delay wrong");

  property p_swing;
    !ext_now |=> output_swing_normal == $past(st_ff.stb[PIN_SWING_LVL]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing select wrong");

  property p_cal_gate;
    extended_mode && cal_permit |-> &regs_written;
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("calibration permitted early");

  property p_des_first;
    ext_now && wr_stb && wr_addr == REG_OFS[DES_IDX] && !st_ff.written[DES_IDX]
      && wr_data != DES_RESET |=> first_write_error && dual_edge_value == DES_RESET;
  endproperty
  a_des_first: assert property (p_des_first) else $error("bad first write accepted");

  property p_dual_gate;
    dual_edge_active |-> &regs_written && dual_edge_value[DES_EN_BIT];
  endproperty
  a_dual_gate: assert property (p_dual_gate) else $error("dual edge enabled early");

  c_ext_entry: cover property (!extended_mode ##1 extended_mode);
  c_all_written: cover property (extended_mode && cal_permit);
  c_ddr: cover property (!extended_mode && ddr_clocking);
  c_dual_edge: cover property (dual_edge_active);

endmodule : conv_mode_select

// ===== host_ctrl_model.sv
// host controller model: drives the strap pins or the serial configuration link
module host_ctrl_model
  import conv_mode_pkg::*;
(
  input  wire logic core_clk,
  output logic      mode_select_level,
  output logic      mode_select_float,
  output logic      output_swing_level,
  output logic      output_swing_float,
  output logic      output_edge_select_level,
  output logic      output_edge_select_float,
  output logic      calibration_delay_select_level,
  output logic      calibration_delay_select_float
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {mode_select_level, mode_select_float, output_swing_level, output_swing_float} = 4'h0;
    {output_edge_select_level, output_edge_select_float} = 2'h0;
    {calibration_delay_select_level, calibration_delay_select_float} = 2'h0;
  end

  // ----------------------------------------------------------------------
  // strap levels: every pin solidly driven, only the edge pin may float
  // ----------------------------------------------------------------------
  task automatic strap(input logic md, input logic sw, input logic ed, input logic cl,
                       input logic ef);
    @(posedge core_clk);
    #1;
    mode_select_level = md;
    mode_select_float = 1'b0;
    output_swing_level = sw;
    output_swing_float = 1'b0;
    output_edge_select_level = ed;
    output_edge_select_float = ef;
    calibration_delay_select_level = cl;
    calibration_delay_select_float = 1'b0;
  endtask : strap

  // ----------------------------------------------------------------------
  // serial link: clock idles low, select idles high between frames
  // ----------------------------------------------------------------------
  task automatic go_ext();
    @(posedge core_clk);
    #1;
    mode_select_float = 1'b1;
    mode_select_level = ~mode_select_level;         // floating pin level means nothing
    {output_swing_float, output_edge_select_float} = 2'h0;
    calibration_delay_select_float = 1'b0;
    output_swing_level = 1'b0;
    calibration_delay_select_level = 1'b1;
  endtask : go_ext

  // nbits below a whole frame lets the bench abort a frame midway
  task automatic frame(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input int nbits);
    logic [FRAME_BITS-1:0] f;
    f = {a, d};
    // select stays high over three edges so the three-stage pin filter sees it
    repeat (3) @(posedge core_clk);
    #1;
    calibration_delay_select_level = 1'b0;
    for (int i = FRAME_BITS - 1; i >= FRAME_BITS - nbits; i--) begin
      output_edge_select_level = f[i];
      #40 output_swing_level = 1'b1;
      #40 output_swing_level = 1'b0;
    end
    #40 calibration_delay_select_level = 1'b1;
    // released data line must not keep showing the last bit
    output_edge_select_level = ~output_edge_select_level;
  endtask : frame

endmodule : host_ctrl_model

// ===== converter_control_mode_select_test.sv
// self-checking bench for the converter control-mode select block
module converter_control_mode_select_test
  import conv_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                core_clk;
  logic                sys_rst;
  logic                mode_select_level, mode_select_float;
  logic                output_swing_level, output_swing_float;
  logic                output_edge_select_level, output_edge_select_float;
  logic                calibration_delay_select_level, calibration_delay_select_float;
  logic                extended_mode, output_swing_normal, data_on_rising_edge;
  logic                ddr_clocking, cal_delay_long, full_scale_normal, cal_permit;
  logic                dual_edge_active, first_write_error;
  logic [NUM_REGS-1:0] regs_written;
  logic [DATA_W-1:0]   dual_edge_value;
  int                  mismatches = 0;
  int                  cmp_count = 0;

  host_ctrl_model i_host_ctrl_model (.core_clk, .mode_select_level, .mode_select_float,
    .output_swing_level, .output_swing_float, .output_edge_select_level,
    .output_edge_select_float, .calibration_delay_select_level,
    .calibration_delay_select_float);

  conv_mode_select i_conv_mode_select (.core_clk, .sys_rst, .mode_select_level,
    .mode_select_float, .output_swing_level, .output_swing_float,
    .output_edge_select_level, .output_edge_select_float,
    .calibration_delay_select_level, .calibration_delay_select_float, .extended_mode,
    .output_swing_normal, .data_on_rising_edge, .ddr_clocking, .cal_delay_long,
    .full_scale_normal, .cal_permit, .dual_edge_active, .first_write_error,
    .regs_written, .dual_edge_value);

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  // sync pipe plus decode take a few edges, so poll with a bound
  task automatic wait_mode(input logic exp);
    for (int i = 0; i < 20 && extended_mode !== exp; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (extended_mode !== exp) begin
      mismatches++;
      $display("Error at %0t: mode change timed out", $time);
      finish_test();
    end
  endtask : wait_mode

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_strap();
    logic [3:0] v;
    for (int k = 0; k < 16; k++) begin
      v = k[3:0];
      i_host_ctrl_model.strap(v[3], v[2], v[1], v[0], 1'b0);
      wait_cyc(6);
      chk(extended_mode, 1'b0, "strap mode");
      chk(cal_permit, 1'b1, "strap permit");
      chk(full_scale_normal, v[3], "range");
      chk(output_swing_normal, v[2], "swing");
      chk(data_on_rising_edge, v[1], "edge");
      chk(ddr_clocking, 1'b0, "single rate");
      chk(cal_delay_long, v[0], "delay");
    end
    i_host_ctrl_model.strap(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    wait_cyc(6);
    chk(ddr_clocking, 1'b1, "double rate");
    i_host_ctrl_model.frame(4'h1, 16'h0000, 20);
    wait_cyc(8);
    chk(regs_written, 8'h00, "strap serial");
  endtask : t_strap

  task automatic t_ext();
    logic [NUM_REGS-1:0] m;
    m = '0;
    i_host_ctrl_model.go_ext();
    wait_mode(1'b1);
    chk(cal_permit, 1'b0, "no permit");
    i_host_ctrl_model.frame(4'h0, 16'h1234, 20);
    wait_cyc(8);
    chk(regs_written, 8'h00, "unmapped");
    i_host_ctrl_model.frame(4'hd, 16'h8000, 20);
    wait_cyc(8);
    chk(first_write_error, 1'b1, "bad first");
    chk(regs_written, 8'h00, "refused");
    chk(dual_edge_value, 16'h3fff, "kept");
    // an aborted frame must leave no trace on the next one
    i_host_ctrl_model.frame(4'h2, 16'hffff, 12);
    for (int k = 0; k < NUM_REGS; k++) begin
      chk(cal_permit, 1'b0, "early permit");
      i_host_ctrl_model.frame(REG_OFS[k], (k == CFG_IDX) ? 16'h0016 : REG_RESET[k], 20);
      wait_cyc(8);
      m[k] = 1'b1;
      chk(regs_written, m, "written");
    end
    wait_cyc(2);
    chk(cal_permit, 1'b1, "permit");
    chk(dual_edge_active, 1'b0, "dual off");
    chk(output_swing_normal, 1'b0, "cfg swing");
    chk(data_on_rising_edge, 1'b1, "cfg edge");
    chk(ddr_clocking, 1'b1, "cfg ddr");
    chk(cal_delay_long, 1'b0, "cfg delay");
    chk(full_scale_normal, 1'b1, "cfg range");
    i_host_ctrl_model.frame(4'hd, 16'hbfff, 20);
    wait_cyc(9);
    chk(dual_edge_active, 1'b1, "dual on");
    chk(dual_edge_value, 16'hbfff, "dual val");
    i_host_ctrl_model.strap(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    wait_mode(1'b0);
    wait_cyc(6);
    chk(dual_edge_active, 1'b0, "strap dual");
    chk(output_swing_normal, 1'b1, "pin swing");
  endtask : t_ext

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    chk(dual_edge_value, 16'h3fff, "reset dual");
    chk(regs_written, 8'h00, "reset written");
    #1 sys_rst = 1'b0;
    t_strap();
    t_ext();
    finish_test();
  end

  initial begin
    #400000;
    mismatches++;
    $display("Error at %0t: run timeout", $time);
    finish_test();
  end

endmodule : converter_control_mode_select_test
